// ==== rtl/ibd_pkg.sv ====
package ibd_pkg;

    // Universal and addressed command codes (low seven bits, ATN true)
    localparam logic [6:0] IBD_CMD_GTL = 7'h01;
    localparam logic [6:0] IBD_CMD_SDC = 7'h04;
    localparam logic [6:0] IBD_CMD_DCL = 7'h14;
    localparam logic [6:0] IBD_CMD_SPE = 7'h18;
    localparam logic [6:0] IBD_CMD_SPD = 7'h19;
    localparam logic [6:0] IBD_CMD_UNL = 7'h3f;
    localparam logic [6:0] IBD_CMD_UNT = 7'h5f;
    localparam logic [1:0] IBD_GRP_LISTEN = 2'h1;
    localparam logic [1:0] IBD_GRP_TALK = 2'h2;

    // Measurement function codes
    localparam logic [3:0] IBD_FN_AC_LEVEL = 4'h0;
    localparam logic [3:0] IBD_FN_RESET = 4'h0;

    // Service request and error bits of the status byte
    localparam int IBD_SB_RQS_BIT = 6;
    localparam int IBD_SB_ERR_BIT = 0;
    localparam logic [7:0] IBD_SB_RESET = 8'h00;

    // Enable-on-error data message "22.4SP"
    localparam int IBD_MSG_LEN = 6;
    localparam logic [47:0] IBD_MSG_SRQ_EN = 48'h32_32_2e_34_53_50;

    // Clock and SRQ response deadline
    localparam int IBD_CLK_NS = 8;
    localparam longint IBD_SRQ_MAX_NS = 64'd2000000000;
    localparam longint IBD_SRQ_MAX_CYC = IBD_SRQ_MAX_NS / IBD_CLK_NS;

    typedef enum logic [1:0] {
        IBD_TK_IDLE = 2'b00,
        IBD_TK_DATA = 2'b01,
        IBD_TK_STAT = 2'b10
    } ibd_talk_t;

    function automatic logic ibd_is_cmd(input logic atn, input logic ifc);
        return atn && !ifc;
    endfunction : ibd_is_cmd

endpackage : ibd_pkg

// ==== rtl/ibd_cmd_decode.sv ====
`timescale 1ns/1ps
module ibd_cmd_decode
    import ibd_pkg::*;
(
    input wire logic [7:0] busData,
    input wire logic [4:0] myAddr,
    output logic isMla,
    output logic isMta,
    output logic isUnl,
    output logic isUnt,
    output logic isGtl,
    output logic isSdc,
    output logic isDcl,
    output logic isSpe,
    output logic isSpd
);
    logic [6:0] code;

    // Parity bit ignored
    assign code = busData[6:0];
    assign isMla = code == {IBD_GRP_LISTEN, myAddr};
    assign isMta = code == {IBD_GRP_TALK, myAddr};
    assign isUnl = code == IBD_CMD_UNL;
    assign isUnt = code == IBD_CMD_UNT;
    assign isGtl = code == IBD_CMD_GTL;
    assign isSdc = code == IBD_CMD_SDC;
    assign isDcl = code == IBD_CMD_DCL;
    assign isSpe = code == IBD_CMD_SPE;
    assign isSpd = code == IBD_CMD_SPD;
endmodule : ibd_cmd_decode

// ==== rtl/ibd_msg_match.sv ====
`timescale 1ns/1ps
module ibd_msg_match
    import ibd_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic byteStb,
    input wire logic [7:0] byteIn,
    output logic hit
);
    typedef struct packed {
        logic [2:0] pos;
    } ibd_match_t;

    ibd_match_t st_ff;
    ibd_match_t nxt_st;

    function automatic logic [7:0] expectAt(input logic [2:0] p);
        return IBD_MSG_SRQ_EN[47 - 8 * p -: 8];
    endfunction : expectAt

    // Match a fixed string; restart on a mismatch
    always_comb begin
        nxt_st = st_ff;
        hit = 1'b0;
        if (byteStb) begin
            if (byteIn == expectAt(st_ff.pos)) begin
                if (st_ff.pos == 3'(IBD_MSG_LEN - 1)) begin
                    hit = 1'b1;
                    nxt_st.pos = 3'h0;
                end else begin
                    nxt_st.pos = st_ff.pos + 3'h1;
                end
            end else if (byteIn == expectAt(3'h0)) begin
                nxt_st.pos = 3'h1;
            end else begin
                nxt_st.pos = 3'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : ibd_msg_match

// ==== rtl/ibd_device_port.sv ====
// Notes on behaviour
// - Device clear selects AC level, keeps remote
// - Abort drops listen-addressed state
// - Abort keeps remote state only while REN is true
// - Abort drops talk-addressed state
// - Abort clears serial-poll mode, readable flag
// - Status byte returned in local or remote
// - Serial-poll mode plus talk sends status
// - Status byte zero after power-up
// - Message 22.4SP enables service on error
// - Enabled error drives SRQ regardless addressing
// - Remote needs REN true and listen address
// - Commands decoded only when ATN, not IFC
`timescale 1ns/1ps
module ibd_device_port
    import ibd_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [4:0] myAddr,
    input wire logic [7:0] busData,
    input wire logic byteStb,
    input wire logic atn,
    input wire logic ifc,
    input wire logic ren,
    input wire logic talkTake,
    input wire logic localKey,
    input wire logic instrError,
    input wire logic [7:0] measData,
    output logic [7:0] talkData,
    output logic talkValid,
    output logic talkIsStatus,
    output logic srqOut,
    output logic srqOe,
    output logic remoteInd,
    output logic addressedInd,
    output logic listenInd,
    output logic talkInd,
    output logic serialPollMode,
    output logic srqEnable,
    output logic [3:0] measFunc,
    output logic [7:0] statusByte
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic remote;
        logic listen;
        logic talk;
        logic spMode;
        logic srqEn;
        logic rqs;
        logic [3:0] func;
        logic [7:0] txData;
        logic txValid;
        logic txStat;
    } ibd_state_t;

    ibd_state_t st_ff;
    ibd_state_t nxt_st;

    logic isMla;
    logic isMta;
    logic isUnl;
    logic isUnt;
    logic isGtl;
    logic isSdc;
    logic isDcl;
    logic isSpe;
    logic isSpd;
    logic cmdStb;
    logic dataStb;
    logic srqHit;
    logic [7:0] sbNow;

    ibd_cmd_decode u_dec (
        .busData(busData),
        .myAddr(myAddr),
        .isMla(isMla),
        .isMta(isMta),
        .isUnl(isUnl),
        .isUnt(isUnt),
        .isGtl(isGtl),
        .isSdc(isSdc),
        .isDcl(isDcl),
        .isSpe(isSpe),
        .isSpd(isSpd)
    );

    // Only bytes sent to us as listener count as data messages
    assign dataStb = byteStb && !atn && st_ff.listen;
    assign cmdStb = byteStb && ibd_is_cmd(atn, ifc);

    ibd_msg_match u_match (
        .clock(clock),
        .sys_rst(sys_rst),
        .byteStb(dataStb),
        .byteIn(busData),
        .hit(srqHit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status byte: RQS plus error summary, zero while idle
    function automatic logic [7:0] statusOf(
        input logic rqs,
        input logic err
    );
        logic [7:0] sb;
        sb = IBD_SB_RESET;
        sb[IBD_SB_RQS_BIT] = rqs;
        sb[IBD_SB_ERR_BIT] = err;
        return sb;
    endfunction : statusOf

    always_comb begin
        sbNow = statusOf(st_ff.rqs, instrError);
    end

    ////////////////////////////////////////////////////////////////////////
    // Abort: unaddress and leave poll mode; remote only follows REN
    function automatic ibd_state_t abortStep(
        input ibd_state_t s,
        input logic renNow
    );
        ibd_state_t n;
        n = s;
        n.listen = 1'b0;
        n.talk = 1'b0;
        n.spMode = 1'b0;
        n.remote = s.remote && renNow;
        return n;
    endfunction : abortStep

    // Addressing; a foreign talk address releases our talker
    function automatic ibd_state_t addrStep(
        input ibd_state_t s,
        input logic renNow,
        input logic mla,
        input logic mta,
        input logic unl,
        input logic otherTalk
    );
        ibd_state_t n;
        n = s;
        // Remote only while REN stands, never carried over without it
        if (mla) begin
            n.listen = 1'b1;
            n.talk = 1'b0;
            n.remote = renNow;
        end else if (unl) begin
            n.listen = 1'b0;
        end
        if (mta) begin
            n.talk = 1'b1;
            n.listen = 1'b0;
        end else if (otherTalk) begin
            n.talk = 1'b0;
        end
        return n;
    endfunction : addrStep

    // Local, clear and poll commands; listener state from before the byte
    function automatic ibd_state_t ctrlStep(
        input ibd_state_t s,
        input logic wasListen,
        input logic gtl,
        input logic sdc,
        input logic dcl,
        input logic spe,
        input logic spd
    );
        ibd_state_t n;
        n = s;
        if (gtl && wasListen) begin
            n.remote = 1'b0;
        end
        // Clear keeps remote and addressing
        if (dcl || (sdc && wasListen)) begin
            n.func = IBD_FN_AC_LEVEL;
        end
        if (spe) begin
            n.spMode = 1'b1;
        end
        if (spd) begin
            n.spMode = 1'b0;
        end
        return n;
    endfunction : ctrlStep

    // What the talker holds, from its valid and status bits
    function automatic ibd_talk_t talkKind(input ibd_state_t s);
        ibd_talk_t k;
        k = IBD_TK_IDLE;
        if (s.txValid) begin
            k = s.txStat ? IBD_TK_STAT : IBD_TK_DATA;
        end
        return k;
    endfunction : talkKind

    // Talker source: status byte in poll mode, otherwise data.
    // A taken byte is never reloaded in the same cycle, so the far side
    // always sees valid low for at least one edge between bytes.
    function automatic ibd_state_t talkStep(
        input ibd_state_t s,
        input ibd_state_t prev,
        input logic busFree,
        input logic take,
        input logic [7:0] meas,
        input logic [7:0] sb
    );
        ibd_state_t n;
        logic taken;
        n = s;
        taken = 1'b0;
        // A loaded byte stands until the far side takes it
        unique case (talkKind(prev))
            IBD_TK_IDLE: begin
                n.txValid = 1'b0;
            end
            IBD_TK_DATA, IBD_TK_STAT: begin
                taken = take;
                n.txValid = !take;
            end
            default: begin
                n.txValid = 1'b0;
            end
        endcase
        if (n.talk && busFree && !n.txValid && !taken) begin
            n.txValid = 1'b1;
            n.txStat = prev.spMode;
            n.txData = prev.spMode ? sb : meas;
        end
        if (!n.talk) begin
            n.txValid = 1'b0;
        end
        return n;
    endfunction : talkStep

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        if (ifc) begin
            // Abort wins over any byte in the same cycle
            nxt_st = abortStep(st_ff, ren);
        end else begin
            // Dropping REN returns to local at once
            if (!ren) begin
                nxt_st.remote = 1'b0;
            end
            if (cmdStb) begin
                nxt_st = addrStep(nxt_st, ren, isMla, isMta, isUnl,
                    isUnt || (busData[6:5] == IBD_GRP_TALK));
                nxt_st = ctrlStep(nxt_st, st_ff.listen, isGtl, isSdc, isDcl,
                    isSpe, isSpd);
            end
            if (localKey) begin
                nxt_st.remote = 1'b0;
            end
            if (srqHit) begin
                nxt_st.srqEn = 1'b1;
            end
        end
        // Request held while enabled error stands; one-cycle latency
        nxt_st.rqs = st_ff.srqEn && instrError;
        nxt_st = talkStep(nxt_st, st_ff, !atn && !ifc, talkTake, measData,
            sbNow);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= '{
                remote: 1'b0,
                listen: 1'b0,
                talk: 1'b0,
                spMode: 1'b0,
                srqEn: 1'b0,
                rqs: 1'b0,
                func: IBD_FN_RESET,
                txData: 8'h00,
                txValid: 1'b0,
                txStat: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign talkData = st_ff.txData;
    assign talkValid = st_ff.txValid;
    assign talkIsStatus = st_ff.txStat;
    // Open-drain SRQ: pull low only, enable marks driving
    assign srqOut = 1'b0;
    assign srqOe = st_ff.rqs;
    assign remoteInd = st_ff.remote;
    assign listenInd = st_ff.listen;
    assign talkInd = st_ff.talk;
    assign addressedInd = st_ff.listen || st_ff.talk;
    assign serialPollMode = st_ff.spMode;
    assign srqEnable = st_ff.srqEn;
    assign measFunc = st_ff.func;
    assign statusByte = sbNow;
endmodule : ibd_device_port

// ==== verification/ibd_device_port_monitor.sv ====
`timescale 1ns/1ps
module ibd_device_port_monitor
    import ibd_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] busData,
    input wire logic byteStb,
    input wire logic atn,
    input wire logic ifc,
    input wire logic ren,
    input wire logic localKey,
    input wire logic instrError,
    input wire logic srqOe,
    input wire logic remoteInd,
    input wire logic listenInd,
    input wire logic talkInd,
    input wire logic serialPollMode,
    input wire logic srqEnable,
    input wire logic [3:0] measFunc,
    input wire logic [7:0] statusByte
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic cmd;
    assign cmd = byteStb && atn && !ifc;
    a_srq_rises: assert property (srqEnable && instrError |=> srqOe)
        else $error("srq late");
    a_ifc_clears: assert property (ifc |=> !listenInd && !talkInd
        && !serialPollMode) else $error("abort left state");
    a_ifc_remote: assert property (ifc && ren && !localKey
        && remoteInd |=> remoteInd) else $error("abort dropped remote");
    a_dcl_level: assert property (cmd && busData[6:0] == IBD_CMD_DCL
        && ren && !localKey |=> measFunc == IBD_FN_AC_LEVEL
        && $stable(remoteInd)) else $error("clear wrong");
    a_spe_poll: assert property (cmd && busData[6:0] == IBD_CMD_SPE
        |=> serialPollMode) else $error("poll mode not set");
    a_remote_ren: assert property ($rose(remoteInd) |-> $past(ren))
        else $error("remote without ren");
    a_status_zero: assert property (!srqEnable && !instrError
        |-> statusByte == IBD_SB_RESET) else $error("status not zero");
    a_data_cmd: assert property (byteStb && !atn && !serialPollMode
        |=> !serialPollMode) else $error("data taken as command");
endmodule : ibd_device_port_monitor
////////////////////////////////////////////////////////////////////////////
bind ibd_device_port ibd_device_port_monitor mon (.clock, .sys_rst,
    .busData, .byteStb, .atn, .ifc, .ren, .localKey, .instrError, .srqOe,
    .remoteInd, .listenInd, .talkInd, .serialPollMode, .srqEnable,
    .measFunc, .statusByte);

// ==== verification/ibd_ctrl_model.sv ====
`timescale 1ns/1ps
module ibd_ctrl_model (
    input wire logic clock,
    output logic [7:0] busData,
    output logic byteStb,
    output logic atn,
    output logic ifc,
    output logic ren,
    output logic talkTake,
    input wire logic talkValid,
    input wire logic [7:0] talkData
);
    initial {busData, byteStb, atn, ifc, ren, talkTake} = '0;
    task automatic send(input logic a, input logic [7:0] b);
        @(posedge clock) #1;
        atn = a;
        busData = b;
        byteStb = 1'b1;
        @(posedge clock) #1;
        byteStb = 1'b0;
        atn = 1'b0;
        // Released lines must not keep the last byte
        busData = ~b;
    endtask : send
    task automatic abort();
        @(posedge clock) #1 ifc = 1'b1;
        @(posedge clock) #1 ifc = 1'b0;
    endtask : abort
    task automatic take(output logic [7:0] d);
        for (int i = 0; i < 16 && !talkValid; i++) @(posedge clock) #1;
        d = talkValid ? talkData : 8'hxx;
        talkTake = 1'b1;
        @(posedge clock) #1 talkTake = 1'b0;
    endtask : take
endmodule : ibd_ctrl_model

// ==== verification/ibd_device_port_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ibd_device_port_tb;
    import ibd_pkg::*;
    logic clock, sys_rst, byteStb, atn, ifc, ren, talkTake, localKey;
    logic instrError, talkValid, talkIsStatus, srqOut, srqOe, remoteInd;
    logic addressedInd, listenInd, talkInd, serialPollMode, srqEnable;
    logic [7:0] busData, measData, talkData, statusByte, rd;
    logic [4:0] myAddr;
    logic [3:0] measFunc;
    int bad_count, comparisons;
    ibd_device_port DUT (.*);
    ibd_ctrl_model m (.clock, .busData, .byteStb, .atn, .ifc, .ren,
        .talkTake, .talkValid, .talkData);
    function automatic logic [7:0] expStat(input logic err, input logic rqs);
        logic [7:0] s;
        s = IBD_SB_RESET;
        s[IBD_SB_ERR_BIT] = err;
        s[IBD_SB_RQS_BIT] = rqs;
        return s;
    endfunction : expStat
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic poll(input logic [7:0] exp);
        m.send(1'b1, {1'b0, IBD_CMD_SPE});
        m.send(1'b1, {3'h2, myAddr});
        m.take(rd);
        `CHK(rd, exp)
        `CHK(talkIsStatus, 1'b1)
        m.send(1'b1, {1'b0, IBD_CMD_SPD});
        m.send(1'b1, {1'b0, IBD_CMD_UNT});
    endtask : poll
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        test_done();
    end
    initial begin
        {sys_rst, myAddr, localKey, instrError, measData} = {1'b1, 15'h0};
        void'($urandom(30841));
        repeat (16) @(posedge clock);
        #1 sys_rst = 1'b0;
        myAddr = 5'($urandom % 31);
        measData = 8'($urandom);
        poll(expStat(1'b0, 1'b0));
        `CHK(remoteInd, 1'b0)
        $display("local poll done");
        m.ren = 1'b1;
        m.send(1'b1, {3'h1, myAddr});
        `CHK(remoteInd, 1'b1)
        poll(expStat(1'b0, 1'b0));
        // Talk address of the poll unlistened us; only selected clear needs a listener
        m.send(1'b1, {3'h1, myAddr});
        m.send(1'b1, {1'b0, IBD_CMD_DCL});
        `CHK({measFunc, remoteInd, listenInd}, {IBD_FN_AC_LEVEL, 2'b11})
        m.abort();
        `CHK({remoteInd, addressedInd}, 2'b10)
        m.send(1'b1, {3'h1, myAddr});
        m.send(1'b1, {1'b0, IBD_CMD_GTL});
        m.send(1'b1, {3'h2, myAddr});
        m.take(rd);
        `CHK({talkInd, talkIsStatus, rd}, {2'b10, measData})
        m.abort();
        `CHK({remoteInd, addressedInd}, 2'b00)
        m.send(1'b1, {1'b0, IBD_CMD_SPE});
        `CHK(serialPollMode, 1'b1)
        m.abort();
        `CHK(serialPollMode, 1'b0)
        m.send(1'b0, {1'b0, IBD_CMD_SPE});
        `CHK(serialPollMode, 1'b0)
        $display("clear and abort done");
        m.send(1'b1, {3'h1, myAddr});
        for (int i = 5; i >= 0; i--) m.send(1'b0, IBD_MSG_SRQ_EN[i*8 +: 8]);
        // Unlisten first: SRQ must not depend on addressing
        m.send(1'b1, {1'b0, IBD_CMD_UNL});
        `CHK({srqEnable, srqOe}, 2'b10)
        repeat ($urandom % 8) @(posedge clock);
        #1 instrError = 1'b1;
        repeat (2) @(posedge clock);
        #1 `CHK({srqOut, srqOe}, 2'b01)
        `CHK(statusByte[IBD_SB_ERR_BIT], 1'b1)
        poll(expStat(1'b1, 1'b1));
        $display("service request done");
        test_done();
    end
endmodule : ibd_device_port_tb
